// ==== sahp_checker.sv ====
// Link-side checks for the multiplexed host port, sampled on the link clock.
// Assumes normal two-cycle latency; the short-latency option is not covered.
`timescale 1ns/100ps
`default_nettype none
module sahp_checker (
  // Clock and reset
  input wire logic i_rst,
  input wire logic link_clk,
  // Link pins
  input wire logic cs_n,
  input wire logic addr_latch_valid_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rdy,
  input wire logic dq_h_oe,
  input wire logic [sahp_pkg::DATA_W-1:0] dq_d_o,
  input wire logic dq_d_oe
);
  import sahp_pkg::*;
  default clocking @(posedge link_clk); endclocking
  default disable iff (i_rst);
  rd_ready_lat_a: assert property (
    $fell(oe_n) && !cs_n |-> !rdy [*3] ##1 rdy) else $error("read ready latency wrong");
  rd_data_lat_a: assert property (
    $fell(oe_n) && !cs_n |-> ##3 dq_d_oe) else $error("read data late");
  rd_data_hold_a: assert property (
    dq_d_oe && !rdy |-> $stable(dq_d_o)) else $error("read data not held");
  rd_ready_len_a: assert property (
    $rose(rdy) && !oe_n |=> (!rdy) or (rdy [*3] ##1 !rdy))
    else $error("read ready length wrong");
  wr_ready_lat_a: assert property (
    $fell(we_n) && !cs_n |-> !rdy [*3] ##1 rdy) else $error("write ready latency wrong");
  wr_ready_len_a: assert property (
    $rose(rdy) && !we_n |-> (rdy [*4] ##1 !rdy) or (rdy [*7] ##1 !rdy))
    else $error("write ready length wrong");
  strobe_order_a: assert property (
    !addr_latch_valid_n |-> oe_n && we_n) else $error("enable during address strobe");
  oe_hold_a: assert property (
    rdy && !$past(oe_n) |-> !oe_n && !cs_n) else $error("output enable dropped early");
  we_hold_a: assert property (
    rdy && !$past(we_n) |-> !we_n && !cs_n) else $error("write enable dropped early");
  no_clash_a: assert property (
    !(dq_h_oe && dq_d_oe)) else $error("both ends drive the data bus");
endmodule
`default_nettype wire

// ==== sahp_dev_end.sv ====
// Device end of the synchronous multiplexed host port, with a small word store.
// Runs on the link clock from the host; reports finished transfers to i_clk.
`timescale 1ns/100ps
`default_nettype none
module sahp_dev_end (
  // Link pins
  sahp_if.dev lnk,
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration levels
  input wire logic i_burst_en,
  input wire logic i_short_lat,
  // Transfer report
  output logic o_done,
  output logic o_done_write,
  output logic [sahp_pkg::DATA_W-1:0] o_done_addr,
  output logic [sahp_pkg::WORDS_W-1:0] o_done_words
);
  import sahp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_LAT, ST_RD, ST_RD_HOLD, ST_WR, ST_WR_TAIL
  } sahp_dev_st_t;

  logic rst_meta_q;
  logic lrst_q;
  logic burst_meta_q;
  logic burst_q;
  logic short_meta_q;
  logic short_q;
  sahp_dev_st_t st_q;
  logic is_wr_q;
  logic [1:0] lat_q;
  logic [1:0] tail_q;
  logic [CNT_W-1:0] wcnt_q;
  logic [WORDS_W-1:0] words_q;
  logic [DATA_W-1:0] addr_q;
  logic [DATA_W-1:0] start_addr_q;
  logic [DATA_W-1:0] addr_nx;
  logic rdy_q;
  logic [DATA_W-1:0] dout_q;
  logic dout_oe_q;
  logic [DATA_W-1:0] mem [MEM_WORDS];
  logic wr_en;
  logic xfer_end;
  logic rd_drop;
  logic wr_drop;
  logic done_tgl_q;
  logic held_write_q;
  logic [DATA_W-1:0] held_addr_q;
  logic [WORDS_W-1:0] held_words_q;
  logic tgl_meta_q;
  logic tgl_s_q;
  logic tgl_d_q;

  // Reset reaches the link domain at once but leaves it on a link edge.
  always_ff @(posedge lnk.link_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_meta_q <= 1'b1;
      lrst_q <= 1'b1;
    end else begin
      rst_meta_q <= 1'b0;
      lrst_q <= rst_meta_q;
    end
  end

  always_ff @(posedge lnk.link_clk or posedge lrst_q) begin
    if (lrst_q) begin
      burst_meta_q <= 1'b0;
      burst_q <= 1'b0;
      short_meta_q <= 1'b0;
      short_q <= 1'b0;
    end else begin
      burst_meta_q <= i_burst_en;
      burst_q <= burst_meta_q;
      short_meta_q <= i_short_lat;
      short_q <= short_meta_q;
    end
  end

  assign addr_nx = addr_q + 16'h0001;
  assign rd_drop = lnk.oe_n | lnk.cs_n;
  assign wr_drop = lnk.we_n | lnk.cs_n;
  // The host launches data while ready is up, so each link edge in ST_WR with write enable and select held takes a word.
  assign wr_en = (st_q == ST_WR) & ~wr_drop;
  assign xfer_end = ((st_q == ST_RD || st_q == ST_RD_HOLD) && rd_drop) ||
                    (st_q == ST_WR && wr_drop) ||
                    (st_q == ST_WR_TAIL && tail_q == 2'h0);

  always_ff @(posedge lnk.link_clk or posedge lrst_q) begin
    if (lrst_q) begin
      st_q <= ST_IDLE;
      is_wr_q <= 1'b0;
      lat_q <= 2'h0;
      tail_q <= 2'h0;
      wcnt_q <= '0;
      words_q <= '0;
      addr_q <= '0;
      start_addr_q <= '0;
      rdy_q <= 1'b0;
      dout_q <= '0;
      dout_oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (!lnk.cs_n && !lnk.addr_latch_valid_n) begin
            addr_q <= lnk.dq;
            start_addr_q <= lnk.dq;
            st_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (lnk.cs_n) begin
            st_q <= ST_IDLE;
          end else if (!lnk.addr_latch_valid_n) begin
            addr_q <= lnk.dq;
            start_addr_q <= lnk.dq;
          end else if (!lnk.oe_n || !lnk.we_n) begin
            // Enables count only once the strobe is released.
            is_wr_q <= lnk.oe_n;
            lat_q <= short_q ? LAT_CNT_SHORT : LAT_CNT_NORMAL;
            st_q <= ST_LAT;
          end
        end
        ST_LAT: begin
          if (is_wr_q ? wr_drop : rd_drop) begin
            st_q <= ST_IDLE;
          end else if (lat_q == 2'h0) begin
            rdy_q <= 1'b1;
            wcnt_q <= burst_q ? BURST_LAST : '0;
            if (is_wr_q) begin
              words_q <= '0;
              st_q <= ST_WR;
            end else begin
              dout_q <= mem[addr_q[MEM_AW-1:0]];
              dout_oe_q <= 1'b1;
              words_q <= 3'h1;
              st_q <= ST_RD;
            end
          end else begin
            lat_q <= lat_q - 2'h1;
          end
        end
        ST_RD: begin
          if (rd_drop) begin
            // An early release loses the rest of the burst.
            rdy_q <= 1'b0;
            dout_oe_q <= 1'b0;
            st_q <= ST_IDLE;
          end else if (wcnt_q == '0) begin
            rdy_q <= 1'b0;
            st_q <= ST_RD_HOLD;
          end else begin
            addr_q <= addr_nx;
            dout_q <= mem[addr_nx[MEM_AW-1:0]];
            words_q <= words_q + 3'h1;
            wcnt_q <= wcnt_q - 2'h1;
          end
        end
        ST_RD_HOLD: begin
          if (rd_drop) begin
            dout_oe_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_WR: begin
          if (wr_drop) begin
            rdy_q <= 1'b0;
            st_q <= ST_IDLE;
          end else begin
            addr_q <= addr_nx;
            words_q <= words_q + 3'h1;
            if (wcnt_q == '0) begin
              tail_q <= WR_TAIL_CNT;
              st_q <= ST_WR_TAIL;
            end else begin
              wcnt_q <= wcnt_q - 2'h1;
            end
          end
        end
        ST_WR_TAIL: begin
          if (tail_q == 2'h0) begin
            rdy_q <= 1'b0;
            st_q <= ST_IDLE;
          end else begin
            tail_q <= tail_q - 2'h1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge lnk.link_clk) begin
    if (wr_en) begin
      mem[addr_q[MEM_AW-1:0]] <= lnk.dq;
    end
  end

  // The held report stays still for many link cycles, far longer than the toggle crossing.
  always_ff @(posedge lnk.link_clk or posedge lrst_q) begin
    if (lrst_q) begin
      done_tgl_q <= 1'b0;
      held_write_q <= 1'b0;
      held_addr_q <= '0;
      held_words_q <= '0;
    end else if (xfer_end) begin
      done_tgl_q <= ~done_tgl_q;
      held_write_q <= is_wr_q;
      held_addr_q <= start_addr_q;
      held_words_q <= words_q;
    end
  end

  assign lnk.rdy = rdy_q;
  assign lnk.dq_d_o = dout_q;
  assign lnk.dq_d_oe = dout_oe_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tgl_meta_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_d_q <= 1'b0;
    end else begin
      tgl_meta_q <= done_tgl_q;
      tgl_s_q <= tgl_meta_q;
      tgl_d_q <= tgl_s_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_done_write <= 1'b0;
      o_done_addr <= '0;
      o_done_words <= '0;
    end else begin
      o_done <= tgl_s_q ^ tgl_d_q;
      if (tgl_s_q ^ tgl_d_q) begin
        o_done_write <= held_write_q;
        o_done_addr <= held_addr_q;
        o_done_words <= held_words_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sahp_host_end.sv ====
// Host end of the synchronous multiplexed host port.
// Makes the link clock from i_clk and needs LINK_HALF_CYC of at least two.
`timescale 1ns/100ps
`default_nettype none
module sahp_host_end (
  // Link pins
  sahp_if.host lnk,
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_burst,
  input wire logic [sahp_pkg::DATA_W-1:0] i_req_addr,
  output logic o_req_ready,
  // Write data
  input wire logic [sahp_pkg::DATA_W-1:0] i_wdata,
  output logic o_wdata_take,
  // Read data and status
  output logic o_rd_valid,
  output logic [sahp_pkg::DATA_W-1:0] o_rd_data,
  output logic o_busy
);
  import sahp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_XFER, H_WR_WAIT} sahp_host_st_t;

  logic [3:0] div_q;
  logic lclk_q;
  logic rise_ev;
  logic fall_ev;
  logic rdy_meta_q;
  logic rdy_s_q;
  logic [DATA_W-1:0] dq_meta_q;
  logic [DATA_W-1:0] dq_s_q;
  logic rdy_smp_q;
  logic [DATA_W-1:0] dq_smp_q;
  sahp_host_st_t st_q;
  logic wr_q;
  logic burst_q;
  logic [CNT_W-1:0] cnt_q;
  logic last_word;
  logic cs_n_q;
  logic strobe_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic [DATA_W-1:0] dq_o_q;
  logic dq_oe_q;

  // The divider never stops, so the device always sees edges after a transfer.
  assign rise_ev = (div_q == LINK_HALF_LAST) & ~lclk_q;
  assign fall_ev = (div_q == LINK_HALF_LAST) & lclk_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q <= 4'h0;
      lclk_q <= 1'b0;
    end else if (div_q == LINK_HALF_LAST) begin
      div_q <= 4'h0;
      lclk_q <= ~lclk_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdy_meta_q <= 1'b0;
      rdy_s_q <= 1'b0;
      dq_meta_q <= '0;
      dq_s_q <= '0;
      rdy_smp_q <= 1'b0;
      dq_smp_q <= '0;
    end else begin
      rdy_meta_q <= lnk.rdy;
      rdy_s_q <= rdy_meta_q;
      dq_meta_q <= lnk.dq;
      dq_s_q <= dq_meta_q;
      if (rise_ev) begin
        // What the device launched on the previous link edge.
        rdy_smp_q <= rdy_s_q;
        dq_smp_q <= dq_s_q;
      end
    end
  end

  assign last_word = burst_q ? (cnt_q == BURST_LAST) : 1'b1;
  assign o_req_ready = (st_q == H_IDLE) & fall_ev;
  assign o_wdata_take = fall_ev & wr_q &
                        ((st_q == H_ADDR) | (st_q == H_XFER & rdy_smp_q & ~last_word));
  assign o_busy = (st_q != H_IDLE);

  // Pins change half a link period after the sampling edge for hold margin.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= H_IDLE;
      wr_q <= 1'b0;
      burst_q <= 1'b0;
      cnt_q <= '0;
      cs_n_q <= 1'b1;
      strobe_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      dq_o_q <= '0;
      dq_oe_q <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= '0;
    end else begin
      o_rd_valid <= 1'b0;
      if (fall_ev) begin
        case (st_q)
          H_IDLE: begin
            if (i_req_valid) begin
              wr_q <= i_req_write;
              burst_q <= i_req_burst;
              cs_n_q <= 1'b0;
              strobe_n_q <= 1'b0;
              dq_o_q <= i_req_addr;
              dq_oe_q <= 1'b1;
              st_q <= H_ADDR;
            end
          end
          H_ADDR: begin
            strobe_n_q <= 1'b1;
            cnt_q <= '0;
            if (wr_q) begin
              we_n_q <= 1'b0;
              dq_o_q <= i_wdata;
            end else begin
              oe_n_q <= 1'b0;
              dq_oe_q <= 1'b0;
            end
            st_q <= H_XFER;
          end
          H_XFER: begin
            if (rdy_smp_q) begin
              if (!wr_q) begin
                o_rd_valid <= 1'b1;
                o_rd_data <= dq_smp_q;
              end
              if (last_word) begin
                if (wr_q) begin
                  st_q <= H_WR_WAIT;
                end else begin
                  oe_n_q <= 1'b1;
                  cs_n_q <= 1'b1;
                  st_q <= H_IDLE;
                end
              end else begin
                cnt_q <= cnt_q + 2'h1;
                if (wr_q) begin
                  dq_o_q <= i_wdata;
                end
              end
            end
          end
          H_WR_WAIT: begin
            if (!rdy_smp_q) begin
              we_n_q <= 1'b1;
              cs_n_q <= 1'b1;
              dq_oe_q <= 1'b0;
              st_q <= H_IDLE;
            end
          end
          default: begin
            st_q <= H_IDLE;
          end
        endcase
      end
    end
  end

  assign lnk.link_clk = lclk_q;
  assign lnk.cs_n = cs_n_q;
  assign lnk.addr_latch_valid_n = strobe_n_q;
  assign lnk.oe_n = oe_n_q;
  assign lnk.we_n = we_n_q;
  assign lnk.dq_h_o = dq_o_q;
  assign lnk.dq_h_oe = dq_oe_q;
endmodule
`default_nettype wire

// ==== sahp_if.sv ====
// Pins of the multiplexed host port between the host end and the device end.
// The shared data wire is resolved here from both ends' output enables.
`timescale 1ns/100ps
`default_nettype none
interface sahp_if;
  import sahp_pkg::*;
  logic link_clk;
  logic cs_n;
  logic addr_latch_valid_n;
  logic oe_n;
  logic we_n;
  logic rdy;
  logic [DATA_W-1:0] dq_h_o;
  logic dq_h_oe;
  logic [DATA_W-1:0] dq_d_o;
  logic dq_d_oe;
  logic [DATA_W-1:0] dq;
  // A bus nobody drives reads as zero in simulation.
  assign dq = dq_d_oe ? dq_d_o : (dq_h_oe ? dq_h_o : '0);
  modport host (output link_clk, cs_n, addr_latch_valid_n, oe_n, we_n, dq_h_o, dq_h_oe,
                input rdy, dq);
  modport dev (input link_clk, cs_n, addr_latch_valid_n, oe_n, we_n, dq,
               output rdy, dq_d_o, dq_d_oe);
endinterface
`default_nettype wire

// ==== sahp_pkg.sv ====
// Constants shared by both ends of the synchronous multiplexed host port.
// Assumes a 200 MHz system clock and a link clock made by the host end.
// Function
// - Both ends launch and sample on one edge; the host end here launches on the falling link edge.
// - Read ready rises two cycles after enable sampled.
// - Read data valid at two cycles, last held.
// - Single read drops ready one cycle after data.
// - Write ready rises two cycles after enable sampled.
// - Single write drops ready three cycles after capture.
// - Burst write drops ready three cycles after last.
// - Burst read drops ready one cycle after last.
// - Ready stays high through a whole burst.
// - Host transfer length is whole bursts.
// - Host holds output enable for whole read burst.
// - Host holds write enable for whole write burst.
// - Optional one-cycle-shorter latency below 50 MHz.
// - Two-cycle latency holds up to 100 MHz.
// - Host enables only after address strobe released.
// - Host keeps the link clock free-running.
`default_nettype none
package sahp_pkg;
  localparam int DATA_W = 16;
  localparam int MEM_AW = 4;
  localparam int MEM_WORDS = 16;
  localparam int CNT_W = 2;
  localparam int WORDS_W = 3;
  localparam logic [CNT_W-1:0] BURST_LAST = 2'h3;
  localparam int LAT_NORMAL = 2;
  localparam int LAT_SHORT = 1;
  localparam logic [1:0] LAT_CNT_NORMAL = 2'(LAT_NORMAL - 1);
  localparam logic [1:0] LAT_CNT_SHORT = 2'(LAT_SHORT - 1);
  localparam int WR_TAIL_CYC = 3;
  localparam logic [1:0] WR_TAIL_CNT = 2'(WR_TAIL_CYC - 1);
  localparam int SHORT_LAT_MAX_MHZ = 50;
  localparam int LINK_MAX_MHZ = 100;
  localparam int FREE_RUN_EDGES = 150;
  localparam int SYS_CLK_NS = 5;
  localparam int LINK_PERIOD_NS = 20;
  localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * SYS_CLK_NS);
  localparam logic [3:0] LINK_HALF_LAST = 4'(LINK_HALF_CYC - 1);
endpackage
`default_nettype wire

// ==== tb.sv ====
// Bench joining host end and device end over the link interface.
// Drives the host user side at falling edges and checks the device report.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sahp_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_burst_en = 1'b0;
  logic i_req_valid = 1'b0;
  logic i_req_write = 1'b0;
  logic i_req_burst = 1'b0;
  logic [DATA_W-1:0] i_req_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic o_req_ready, o_wdata_take, o_rd_valid, o_busy;
  logic [DATA_W-1:0] o_rd_data;
  logic o_done, o_done_write;
  logic [DATA_W-1:0] o_done_addr;
  logic [WORDS_W-1:0] o_done_words;
  logic [DATA_W-1:0] exp_mem [MEM_WORDS];
  // Short latency is only legal on a slow link, so it follows the link period.
  logic i_short_lat = (1000 / LINK_PERIOD_NS) < SHORT_LAT_MAX_MHZ;
  int n_fail = 0;
  int comparisons = 0;
  int cyc_cnt = 0;
  int edges;
  sahp_if lnk_if ();
  sahp_host_end sahp_host_end_inst (.lnk(lnk_if), .i_clk(i_clk), .i_rst(i_rst),
    .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_burst(i_req_burst),
    .i_req_addr(i_req_addr), .o_req_ready(o_req_ready), .i_wdata(i_wdata),
    .o_wdata_take(o_wdata_take), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .o_busy(o_busy));
  sahp_dev_end sahp_dev_end_inst (.lnk(lnk_if), .i_clk(i_clk), .i_rst(i_rst),
    .i_burst_en(i_burst_en), .i_short_lat(i_short_lat), .o_done(o_done),
    .o_done_write(o_done_write), .o_done_addr(o_done_addr), .o_done_words(o_done_words));
  sahp_checker sahp_checker_inst (.i_rst(i_rst), .link_clk(lnk_if.link_clk),
    .cs_n(lnk_if.cs_n), .addr_latch_valid_n(lnk_if.addr_latch_valid_n),
    .oe_n(lnk_if.oe_n), .we_n(lnk_if.we_n), .rdy(lnk_if.rdy), .dq_h_oe(lnk_if.dq_h_oe),
    .dq_d_o(lnk_if.dq_d_o), .dq_d_oe(lnk_if.dq_d_oe));
  always #2.5 i_clk = ~i_clk;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [DATA_W-1:0] wpat(input logic [DATA_W-1:0] a, input int k);
    return 16'hC35A ^ (a << 4) ^ 16'(k);
  endfunction
  // Counts link clock edges seen over a number of system clock cycles.
  task automatic count_edges(input int cycles, output int n);
    logic prev;
    n = 0;
    @(posedge i_clk);
    prev = lnk_if.link_clk;
    for (int i = 0; i < cycles; i++) begin
      @(posedge i_clk);
      if (lnk_if.link_clk !== prev) n++;
      prev = lnk_if.link_clk;
    end
  endtask
  // One whole transfer: request, data words, and the device's end-of-transfer report.
  task automatic xfer(input logic wr, input logic bst, input logic [DATA_W-1:0] addr);
    int words;
    int k;
    int nr;
    logic got;
    logic acc;
    logic take;
    words = bst ? 4 : 1;
    k = 0;
    nr = 0;
    got = 1'b0;
    acc = 1'b0;
    @(negedge i_clk);
    if (i_burst_en !== bst) begin
      // The burst level is synchronised into the link domain, so let it settle.
      i_burst_en = bst;
      repeat (16) @(negedge i_clk);
    end
    i_req_valid = 1'b1;
    i_req_write = wr;
    i_req_burst = bst;
    i_req_addr = addr;
    i_wdata = wpat(addr, 0);
    for (int c = 0; c < 400 && !(got && (wr ? k == words : nr == words)); c++) begin
      @(posedge i_clk);
      take = o_wdata_take;
      acc = acc | o_req_ready;
      if (o_rd_valid === 1'b1) begin
        chk(o_rd_data, exp_mem[4'(addr + 16'(nr))]);
        nr++;
      end
      if (o_done === 1'b1) begin
        got = 1'b1;
        chk({15'h0000, o_done_write}, {15'h0000, wr});
        chk(o_done_addr, addr);
        chk({13'h0000, o_done_words}, 16'(words));
      end
      @(negedge i_clk);
      if (acc) i_req_valid = 1'b0;
      if (take === 1'b1) begin
        chk({15'h0000, o_busy}, 16'h0001);
        exp_mem[4'(addr + 16'(k))] = wpat(addr, k);
        k++;
        i_wdata = wpat(addr, k);
      end
    end
    chk({15'h0000, got}, 16'h0001);
    $display("test wr=%0d burst=%0d addr=%h ended", wr, bst, addr);
  endtask
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (20) @(negedge i_clk);
    count_edges(40, edges);
    chk(16'(edges), 16'(40 / LINK_HALF_CYC));
    $display("test link clock ended");
    xfer(1'b1, 1'b0, 16'h0003);
    xfer(1'b0, 1'b0, 16'h0003);
    xfer(1'b1, 1'b1, 16'h000E);
    xfer(1'b0, 1'b1, 16'h000E);
    xfer(1'b1, 1'b0, 16'h1235);
    xfer(1'b0, 1'b0, 16'h0005);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 1'b0, 16'h000E + 16'(i));
    end
    @(negedge i_clk);
    chk({15'h0000, o_busy}, 16'h0000);
    count_edges(FREE_RUN_EDGES * LINK_HALF_CYC, edges);
    chk(16'(edges), 16'(FREE_RUN_EDGES));
    $display("test idle link clock ended");
    wrap_up();
  end
endmodule
`default_nettype wire
